/* File: pms_device.sv */
`timescale 1ns/1ps
`include "pms_defines.svh"

module pms_device #(
	parameter int NUM_PAGES = 4,
	parameter int C45_DEPTH = 16
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Management link
	pms_mgmt_if.device       link,
	// Configuration
	input  wire logic [4:0]  phy_addr,
	// Register activity
	output logic             wr_pulse,
	output logic      [4:0]  wr_addr,
	output logic      [15:0] wr_data,
	output logic      [15:0] page_sel
);
	import pms_pkg::*;

	localparam int PW = $clog2(NUM_PAGES);
	localparam int CW = $clog2(C45_DEPTH);

	// Upper half of the map is paged except the page select at 31, lower half is not
	function automatic logic [PW+3:0] page_index(input logic [15:0] page,
		input logic [4:0] addr);
		page_index = {page[PW-1:0], addr[3:0]};
	endfunction : page_index

	// ****************************************
	// Storage
	// ****************************************
	logic [15:0] base_mem [0:15];
	logic [15:0] page_mem [0:NUM_PAGES*16-1];
	logic [15:0] c45_mem  [0:C45_DEPTH-1];
	logic [15:0] page_reg;
	logic [15:0] c45_ctrl_reg;
	logic [15:0] c45_addr_reg;

	// ****************************************
	// Frame state
	// ****************************************
	pms_dev_state_t state_reg;
	logic [3:0]     cnt_reg;
	logic [15:0]    sh_reg;
	logic           is_wr_reg;
	logic           is_rd_reg;
	logic           match_reg;
	logic [4:0]     addr_reg;
	logic [15:0]    tx_reg;
	logic           dio_o_reg;
	logic           dio_oe_reg;
	logic           mdc_s1_reg;
	logic           mdc_s2_reg;
	logic           mdc_s3_reg;
	logic           dio_s1_reg;
	logic           dio_s2_reg;

	// ****************************************
	// Decode
	// ****************************************
	// No timeout anywhere: a stopped MDC simply freezes the frame
	wire        mdc_rise  = mdc_s2_reg & ~mdc_s3_reg;
	wire        bit_in    = dio_s2_reg;
	wire [11:0] hdr_word  = {sh_reg[10:0], bit_in};
	wire [1:0]  op_code   = {sh_reg[0], bit_in};
	wire        op_ok     = (op_code == `PMS_OP_READ) || (op_code == `PMS_OP_WRITE);
	wire        hdr_read  = hdr_word[11:10] == `PMS_OP_READ;
	wire        addr_hit  = hdr_word[9:5] == phy_addr;
	wire [4:0]  hdr_reg   = hdr_word[4:0];
	wire        in_hdr    = mdc_rise && (state_reg == DV_HDR);
	wire        hdr_done  = in_hdr && (cnt_reg == `PMS_HDR_LAST);
	wire        rd_take   = hdr_done && hdr_read && addr_hit;
	wire        data_last = mdc_rise && (state_reg == DV_DATA) && (cnt_reg == `PMS_DATA_LAST);
	wire        wr_take   = data_last && is_wr_reg && match_reg;
	wire [15:0] wr_word   = {sh_reg[14:0], bit_in};
	wire        rd_active = mdc_rise && is_rd_reg && match_reg;

	wire [1:0]    c45_func  = c45_ctrl_reg[15:14];
	wire [CW-1:0] c45_idx   = c45_addr_reg[CW-1:0];
	wire          c45_data  = c45_func != `PMS_C45_FN_ADDR;
	wire [15:0]   c45_word  = c45_data ? c45_mem[c45_idx] : c45_addr_reg;
	wire          c45_inc_r = rd_take && (hdr_reg == `PMS_REG_C45_DATA) &&
		(c45_func == `PMS_C45_FN_INC_RW);
	wire          wr_pg     = wr_take && (addr_reg == `PMS_REG_PAGE_SEL);
	wire          wr_c45c   = wr_take && (addr_reg == `PMS_REG_C45_CTRL);
	wire          wr_c45d   = wr_take && (addr_reg == `PMS_REG_C45_DATA);
	wire          wr_paged  = wr_take && addr_reg[4] && !wr_pg;
	wire          wr_base   = wr_take && !addr_reg[4] && !wr_c45c && !wr_c45d;
	wire          c45_inc_w = wr_c45d &&
		((c45_func == `PMS_C45_FN_INC_RW) || (c45_func == `PMS_C45_FN_INC_WR));

	wire [15:0] rd_word = (hdr_reg == `PMS_REG_PAGE_SEL) ? page_reg :
		(hdr_reg == `PMS_REG_C45_CTRL) ? c45_ctrl_reg :
		(hdr_reg == `PMS_REG_C45_DATA) ? c45_word :
		hdr_reg[4] ? page_mem[page_index(page_reg, hdr_reg)] :
		base_mem[hdr_reg[3:0]];

	wire drive_zero = rd_active && (state_reg == DV_TA) && (cnt_reg == 4'h0);
	wire drive_next = rd_active && (((state_reg == DV_TA) && (cnt_reg == 4'h1)) ||
		((state_reg == DV_DATA) && (cnt_reg != `PMS_DATA_LAST)));

	assign link.dev_mdio_o  = dio_o_reg;
	assign link.dev_mdio_oe = dio_oe_reg;
	assign page_sel         = page_reg;

	// ****************************************
	// Synchronisers
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mdc_s1_reg <= 1'b0;
			mdc_s2_reg <= 1'b0;
			mdc_s3_reg <= 1'b0;
			dio_s1_reg <= 1'b1;
			dio_s2_reg <= 1'b1;
		end else begin
			mdc_s1_reg <= link.mdc;
			mdc_s2_reg <= mdc_s1_reg;
			mdc_s3_reg <= mdc_s2_reg;
			dio_s1_reg <= link.mdio;
			dio_s2_reg <= dio_s1_reg;
		end
	end

	// ****************************************
	// Frame machine
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= DV_INIT;
			cnt_reg   <= 4'h0;
			sh_reg    <= 16'h0000;
			is_wr_reg <= 1'b0;
			is_rd_reg <= 1'b0;
			match_reg <= 1'b0;
			addr_reg  <= 5'h00;
		end else if (mdc_rise) begin
			unique case (state_reg)
				DV_INIT: begin
					if (!bit_in) begin
						cnt_reg <= 4'h0;
					end else if (cnt_reg == `PMS_INIT_LAST) begin
						state_reg <= DV_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				DV_IDLE: begin
					if (!bit_in) begin
						state_reg <= DV_SFD;
					end
				end
				DV_SFD: begin
					state_reg <= bit_in ? DV_HDR : DV_SKIP;
					cnt_reg   <= 4'h0;
				end
				DV_SKIP: begin
					if (bit_in) begin
						state_reg <= DV_IDLE;
					end
				end
				DV_HDR: begin
					sh_reg  <= {sh_reg[14:0], bit_in};
					cnt_reg <= cnt_reg + 4'h1;
					if ((cnt_reg == 4'h1) && !op_ok) begin
						state_reg <= DV_SKIP;
					end else if (hdr_done) begin
						state_reg <= DV_TA;
						cnt_reg   <= 4'h0;
						is_rd_reg <= hdr_read;
						is_wr_reg <= !hdr_read;
						match_reg <= addr_hit;
						addr_reg  <= hdr_reg;
					end
				end
				DV_TA: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == 4'h1) begin
						state_reg <= DV_DATA;
						cnt_reg   <= 4'h0;
					end
				end
				DV_DATA: begin
					sh_reg  <= {sh_reg[14:0], bit_in};
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == `PMS_DATA_LAST) begin
						state_reg <= DV_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Read driver
	// ****************************************
	// Released by default so the pull-up owns the idle line
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_reg     <= 16'h0000;
			dio_o_reg  <= 1'b1;
			dio_oe_reg <= 1'b0;
		end else if (rd_take) begin
			tx_reg <= rd_word;
		end else if (drive_zero) begin
			dio_oe_reg <= 1'b1;
			dio_o_reg  <= 1'b0;
		end else if (drive_next) begin
			dio_o_reg <= tx_reg[15];
			tx_reg    <= {tx_reg[14:0], 1'b0};
		end else if (data_last) begin
			dio_oe_reg <= 1'b0;
			dio_o_reg  <= 1'b1;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				base_mem[i] <= `PMS_MEM_RST;
			end
			for (int i = 0; i < NUM_PAGES * 16; i++) begin
				page_mem[i] <= `PMS_MEM_RST;
			end
			for (int i = 0; i < C45_DEPTH; i++) begin
				c45_mem[i] <= `PMS_MEM_RST;
			end
			page_reg     <= `PMS_PAGE_SEL_RST;
			c45_ctrl_reg <= `PMS_MEM_RST;
			c45_addr_reg <= `PMS_MEM_RST;
		end else begin
			if (wr_base) begin
				base_mem[addr_reg[3:0]] <= wr_word;
			end
			if (wr_paged) begin
				page_mem[page_index(page_reg, addr_reg)] <= wr_word;
			end
			if (wr_pg) begin
				page_reg <= wr_word;
			end
			if (wr_c45c) begin
				c45_ctrl_reg <= wr_word;
			end
			if (wr_c45d && c45_data) begin
				c45_mem[c45_idx] <= wr_word;
			end
			if (wr_c45d && !c45_data) begin
				c45_addr_reg <= wr_word;
			end else if (c45_inc_r || c45_inc_w) begin
				c45_addr_reg <= c45_addr_reg + 16'h0001;
			end
		end
	end

	// ****************************************
	// Write report
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pulse <= 1'b0;
			wr_addr  <= 5'h00;
			wr_data  <= 16'h0000;
		end else begin
			wr_pulse <= wr_take;
			if (wr_take) begin
				wr_addr <= addr_reg;
				wr_data <= wr_word;
			end
		end
	end

endmodule : pms_device

/* File: pms_defines.svh */
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define PMS_CLK_PERIOD_NS     8
`define PMS_MDC_MIN_PERIOD_NS 80
`define PMS_MDC_HALF_CYC      ((`PMS_MDC_MIN_PERIOD_NS + 2 * `PMS_CLK_PERIOD_NS - 1) / (2 * `PMS_CLK_PERIOD_NS))
`define PMS_PRE_BITS          32
`define PMS_INIT_LAST         4'h1

// ****************************************
// Frame layout
// ****************************************
`define PMS_SFD               2'b01
`define PMS_OP_READ           2'b10
`define PMS_OP_WRITE          2'b01
`define PMS_TA_WR             2'b10
`define PMS_HDR_LAST          4'hb
`define PMS_DATA_LAST         4'hf
`define PMS_FRAME_BITS        32
`define PMS_READ_DRIVE_BITS   14

// ****************************************
// Device register map
// ****************************************
`define PMS_REG_C45_CTRL      5'h0d
`define PMS_REG_C45_DATA      5'h0e
`define PMS_REG_PAGE_SEL      5'h1f
`define PMS_PAGE_SEL_RST      16'h0000
`define PMS_MEM_RST           16'h0000
`define PMS_C45_FN_ADDR       2'b00
`define PMS_C45_FN_INC_RW     2'b10
`define PMS_C45_FN_INC_WR     2'b11

// ****************************************
// Controller register map
// ****************************************
`define PMS_OFS_CTRL          4'h0
`define PMS_OFS_WDATA         4'h4
`define PMS_OFS_STATUS        4'h8
`define PMS_OFS_RDATA         4'hc
`define PMS_CTRL_REG_MSB      4
`define PMS_CTRL_REG_LSB      0
`define PMS_CTRL_PHY_MSB      9
`define PMS_CTRL_PHY_LSB      5
`define PMS_CTRL_WR_BIT       10
`define PMS_CTRL_GO_BIT       11
`define PMS_STAT_BUSY_BIT     0
`define PMS_STAT_DONE_BIT     1
`define PMS_STAT_TAERR_BIT    2

`endif

/* File: pms_pkg.sv */
package pms_pkg;

	typedef enum logic [2:0] {
		DV_INIT,
		DV_IDLE,
		DV_SFD,
		DV_SKIP,
		DV_HDR,
		DV_TA,
		DV_DATA
	} pms_dev_state_t;

	typedef enum logic {
		H_IDLE,
		H_RUN
	} pms_host_state_t;

endpackage : pms_pkg

/* File: pms_mgmt_if.sv */
`timescale 1ns/1ps
interface pms_mgmt_if;
	logic mdc;
	logic dev_mdio_o;
	logic dev_mdio_oe;
	logic host_mdio_o;
	logic host_mdio_oe;
	logic mdio;

	// Pull-up holds the line high when nobody drives
	assign mdio = host_mdio_oe ? host_mdio_o : (dev_mdio_oe ? dev_mdio_o : 1'b1);

	modport device (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe);
	modport host (output mdc, output host_mdio_o, output host_mdio_oe, input mdio);
endinterface : pms_mgmt_if

/* File: pms_host.sv */
`timescale 1ns/1ps
`include "pms_defines.svh"

module pms_host #(
	parameter int PRE_BITS = `PMS_PRE_BITS,
	parameter int HALF_CYC = `PMS_MDC_HALF_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Management link
	pms_mgmt_if.host         link,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);
	import pms_pkg::*;

	localparam int TOTAL = PRE_BITS + `PMS_FRAME_BITS;

	// Returns {output enable, level} for bit idx of a transfer
	function automatic logic [1:0] host_bit(input logic [6:0] idx, input logic [31:0] frame,
		input logic wr);
		logic [6:0] pos;
		pos = idx - 7'(PRE_BITS);
		if (idx < 7'(PRE_BITS)) begin
			host_bit = 2'b11;
		end else begin
			host_bit = {wr || (pos < 7'(`PMS_READ_DRIVE_BITS)), frame[5'd31 - pos[4:0]]};
		end
	endfunction : host_bit

	// ****************************************
	// State
	// ****************************************
	pms_host_state_t state_reg;
	logic [7:0]      half_cnt_reg;
	logic [6:0]      bit_idx_reg;
	logic [31:0]     frame_reg;
	logic            wr_reg;
	logic            mdc_reg;
	logic            dio_o_reg;
	logic            dio_oe_reg;
	logic            dio_s1_reg;
	logic            dio_s2_reg;
	logic [15:0]     rdata_reg;
	logic [15:0]     wdata_reg;
	logic [10:0]     ctrl_reg;
	logic            done_reg;
	logic            ta_err_reg;

	// ****************************************
	// Bus decode
	// ****************************************
	wire        bus_req    = avs_read | avs_write;
	wire        bus_take   = bus_req & ~avs_waitrequest;
	wire        bus_first  = bus_req & avs_waitrequest;
	wire        busy       = state_reg == H_RUN;
	wire        wr_ctrl    = avs_write & bus_take & (avs_address == `PMS_OFS_CTRL);
	wire        wr_wdata   = avs_write & bus_take & (avs_address == `PMS_OFS_WDATA);
	wire        wr_status  = avs_write & bus_take & (avs_address == `PMS_OFS_STATUS);
	wire        go         = wr_ctrl & avs_writedata[`PMS_CTRL_GO_BIT] & ~busy;
	wire        nx_wr      = avs_writedata[`PMS_CTRL_WR_BIT];
	wire [31:0] go_frame   = {`PMS_SFD, nx_wr ? `PMS_OP_WRITE : `PMS_OP_READ,
		avs_writedata[`PMS_CTRL_PHY_MSB:`PMS_CTRL_PHY_LSB],
		avs_writedata[`PMS_CTRL_REG_MSB:`PMS_CTRL_REG_LSB],
		`PMS_TA_WR, nx_wr ? wdata_reg : 16'h0000};
	wire [31:0] status     = {29'h0, ta_err_reg, done_reg, busy};
	wire [31:0] rd_mux     = (avs_address == `PMS_OFS_CTRL)   ? {21'h0, ctrl_reg} :
		(avs_address == `PMS_OFS_WDATA)  ? {16'h0, wdata_reg} :
		(avs_address == `PMS_OFS_STATUS) ? status :
		(avs_address == `PMS_OFS_RDATA)  ? {16'h0, rdata_reg} : 32'h0;

	// ****************************************
	// Link timing
	// ****************************************
	wire       tick      = busy && (half_cnt_reg == 8'(HALF_CYC - 1));
	wire       rise      = tick & ~mdc_reg;
	wire       fall      = tick & mdc_reg;
	wire       last      = bit_idx_reg == 7'(TOTAL - 1);
	wire       in_frame  = bit_idx_reg >= 7'(PRE_BITS);
	wire [6:0] pos       = bit_idx_reg - 7'(PRE_BITS);
	wire [1:0] first_bit = host_bit(7'h00, go_frame, nx_wr);
	wire [1:0] nxt_bit   = host_bit(bit_idx_reg + 7'h01, frame_reg, wr_reg);
	wire       cap_ta    = rise && in_frame && !wr_reg && (pos == 7'h0f);
	wire       cap_data  = rise && in_frame && !wr_reg && (pos >= 7'h10);

	assign link.mdc          = mdc_reg;
	assign link.host_mdio_o  = dio_o_reg;
	assign link.host_mdio_oe = dio_oe_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dio_s1_reg <= 1'b1;
			dio_s2_reg <= 1'b1;
		end else begin
			dio_s1_reg <= link.mdio;
			dio_s2_reg <= dio_s1_reg;
		end
	end

	// MDC made here by division; bits change on the falling edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= H_IDLE;
			half_cnt_reg <= 8'h00;
			bit_idx_reg  <= 7'h00;
			frame_reg    <= 32'h0;
			wr_reg       <= 1'b0;
			mdc_reg      <= 1'b0;
			dio_o_reg    <= 1'b1;
			dio_oe_reg   <= 1'b0;
		end else if (go) begin
			state_reg    <= H_RUN;
			half_cnt_reg <= 8'h00;
			bit_idx_reg  <= 7'h00;
			frame_reg    <= go_frame;
			wr_reg       <= nx_wr;
			mdc_reg      <= 1'b0;
			{dio_oe_reg, dio_o_reg} <= first_bit;
		end else if (busy) begin
			half_cnt_reg <= tick ? 8'h00 : half_cnt_reg + 8'h01;
			if (rise) begin
				mdc_reg <= 1'b1;
			end
			if (fall) begin
				mdc_reg <= 1'b0;
				if (last) begin
					state_reg  <= H_IDLE;
					dio_oe_reg <= 1'b0;
					dio_o_reg  <= 1'b1;
				end else begin
					bit_idx_reg <= bit_idx_reg + 7'h01;
					{dio_oe_reg, dio_o_reg} <= nxt_bit;
				end
			end
		end
	end

	// Done is set by the link and cleared by software; set wins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg  <= 16'h0000;
			ta_err_reg <= 1'b0;
			done_reg   <= 1'b0;
		end else begin
			if (cap_data) begin
				rdata_reg <= {rdata_reg[14:0], dio_s2_reg};
			end
			if (go) begin
				ta_err_reg <= 1'b0;
			end else if (cap_ta) begin
				ta_err_reg <= dio_s2_reg;
			end
			if (fall && last) begin
				done_reg <= 1'b1;
			end else if (wr_status && avs_writedata[`PMS_STAT_DONE_BIT]) begin
				done_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Avalon slave
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
			wdata_reg       <= 16'h0000;
			ctrl_reg        <= 11'h000;
		end else begin
			avs_waitrequest <= ~bus_first;
			if (bus_first) begin
				avs_readdata <= rd_mux;
			end
			if (wr_wdata && !busy) begin
				wdata_reg <= avs_writedata[15:0];
			end
			if (wr_ctrl && !busy) begin
				ctrl_reg <= avs_writedata[10:0];
			end
		end
	end

endmodule : pms_host

/* File: pms_link_properties.sv */
`timescale 1ns/1ps
module pms_link_properties #(
	parameter int PRE_BITS = 2,
	parameter int HALF_CYC = 5
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Link signals
	input wire logic mdc,
	input wire logic dev_mdio_o,
	input wire logic dev_mdio_oe,
	input wire logic host_mdio_o,
	input wire logic host_mdio_oe,
	input wire logic mdio
);
	// ****************************************
	// Helper counters
	// ****************************************
	localparam int OE_LO = 34 * HALF_CYC - 1;
	localparam int OE_HI = 34 * HALF_CYC + 1;
	logic        mdc_d_reg;
	int unsigned rise_cnt_reg;
	int unsigned oe_cnt_reg;
	wire         mdc_rise = mdc & ~mdc_d_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mdc_d_reg    <= 1'b0;
			rise_cnt_reg <= 0;
			oe_cnt_reg   <= 0;
		end else begin
			mdc_d_reg    <= mdc;
			rise_cnt_reg <= host_mdio_oe ? rise_cnt_reg + 32'(mdc_rise) : 0;
			oe_cnt_reg   <= dev_mdio_oe ? oe_cnt_reg + 1 : 0;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_no_fight; !(host_mdio_oe && dev_mdio_oe); endproperty
	property p_ta_release; $rose(dev_mdio_oe) |-> !$past(host_mdio_oe, 4); endproperty
	property p_ta_zero; $rose(dev_mdio_oe) |-> !dev_mdio_o; endproperty
	property p_ta_line; $rose(dev_mdio_oe) |-> !mdio; endproperty
	property p_drive_on_rise;
		dev_mdio_oe && $past(dev_mdio_oe) && $changed(dev_mdio_o) |-> mdc;
	endproperty
	property p_bit_holds;
		dev_mdio_oe && $changed(dev_mdio_o) |=> (!dev_mdio_oe || $stable(dev_mdio_o)) [*8];
	endproperty
	property p_release; $fell(dev_mdio_oe) |-> oe_cnt_reg inside {[OE_LO:OE_HI]}; endproperty
	property p_frame_len;
		$fell(host_mdio_oe) |-> rise_cnt_reg == PRE_BITS + 14 || rise_cnt_reg == PRE_BITS + 32;
	endproperty
	property p_host_on_low; host_mdio_oe && $changed(host_mdio_o) |-> !mdc; endproperty
	property p_mdc_high; $rose(mdc) |=> mdc [*4]; endproperty

	a_no_fight: assert property (p_no_fight)
		else $error("both ends drive the line");
	a_ta_release: assert property (p_ta_release)
		else $error("first turnaround bit not released");
	a_ta_zero: assert property (p_ta_zero)
		else $error("second turnaround bit not zero");
	a_ta_line: assert property (p_ta_line)
		else $error("line not low on second turnaround bit");
	a_drive_on_rise: assert property (p_drive_on_rise)
		else $error("read bit changed while clock low");
	a_bit_holds: assert property (p_bit_holds)
		else $error("read bit did not hold");
	a_release: assert property (p_release)
		else $error("device drive span wrong");
	a_frame_len: assert property (p_frame_len)
		else $error("host frame length wrong");
	a_host_on_low: assert property (p_host_on_low)
		else $error("host bit changed while clock high");
	a_mdc_high: assert property (p_mdc_high)
		else $error("clock high phase too short");

	c_read: cover property ($rose(dev_mdio_oe));
	c_write: cover property ($fell(host_mdio_oe) && rise_cnt_reg == PRE_BITS + 32);
	c_release: cover property ($fell(dev_mdio_oe));
endmodule : pms_link_properties

/* File: phy_mgmt_serial_slave_bench.sv */
`timescale 1ns/1ps
module phy_mgmt_serial_slave_bench;
	// ****************************************
	// Design and link
	// ****************************************
	localparam int PRE = 2;
	localparam int HC  = 5;
	logic        ref_clk, rst_n, avs_read, avs_write;
	logic [4:0]  phy_addr;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, wr_pulse;
	wire  [4:0]  wr_addr;
	wire  [15:0] wr_data, page_sel;
	int          fail_count, total_checks, wr_seen, seed, page;
	int          mem [4][32];

	pms_mgmt_if mif();
	pms_host #(.PRE_BITS(PRE), .HALF_CYC(HC)) pms_host_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.link(mif), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	pms_device pms_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(mif),
		.phy_addr(phy_addr), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data),
		.page_sel(page_sel));
	pms_link_properties #(.PRE_BITS(PRE), .HALF_CYC(HC)) pms_link_properties_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .mdc(mif.mdc), .dev_mdio_o(mif.dev_mdio_o),
		.dev_mdio_oe(mif.dev_mdio_oe), .host_mdio_o(mif.host_mdio_o),
		.host_mdio_oe(mif.host_mdio_oe), .mdio(mif.mdio));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (wr_pulse === 1'b1) wr_seen++;
	// Generous: about forty-five frames of some 350 cycles each
	initial begin
		repeat (80000) @(posedge ref_clk);
		fail_count++;
		print_verdict();
	end

	// ****************************************
	// Tasks and model
	// ****************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// Entered right after a rising edge; leaves one idle edge behind
	task automatic avm(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask : avm

	task automatic xfer(input logic wr, input logic [4:0] ph, input logic [4:0] rg,
		input logic [15:0] d, output logic [15:0] q, output logic ta);
		logic [31:0] r;
		avm(1'b1, 4'h4, {16'h0, d}, r);
		avm(1'b1, 4'h0, {20'h0, 1'b1, wr, ph, rg}, r);
		do avm(1'b0, 4'h8, 32'h0, r); while (r[1] !== 1'b1);
		ta = r[2];
		avm(1'b1, 4'h8, 32'h2, r);
		avm(1'b0, 4'hc, 32'h0, r);
		q = r[15:0];
	endtask : xfer

	// Registers 13 and 14 are left to their own scenario
	function automatic int pick();
		int v;
		v = $unsigned($random(seed)) % 32;
		return (v == 13 || v == 14) ? 12 : v;
	endfunction : pick

	function automatic int mrd(input int r);
		return (r == 31) ? page : mem[(r >= 16) ? page % 4 : 0][r];
	endfunction : mrd

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] q;
		logic [15:0] rd;
		logic        ta;
		int          r, d, w;
		seed = 32'h0e326ef7;
		rst_n = 1'b0;
		phy_addr = 5'h0b;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		page = 0;
		mem = '{default: 0};
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		avm(1'b0, 4'h2, 32'h0, q);
		chk("unmapped", q, 32'h0);
		avm(1'b0, 4'h8, 32'h0, q);
		chk("status", q, 32'h0);
		chk("page_sel", page_sel, 32'h0);
		for (int i = 0; i < 16; i++) begin
			r = (i % 4 == 0) ? 31 : pick();
			d = $random(seed) & 16'hffff;
			w = wr_seen;
			xfer(1'b1, 5'h0b, r[4:0], d[15:0], rd, ta);
			if (r == 31) page = d;
			else mem[(r >= 16) ? page % 4 : 0][r] = d;
			chk("wr_pulse", wr_seen, w + 1);
			chk("wr_addr", wr_addr, r);
			chk("wr_data", wr_data, d);
			chk("page_sel", page_sel, page);
			if (i % 2 == 1) r = pick();
			xfer(1'b0, 5'h0b, r[4:0], 16'h0, rd, ta);
			chk("read", rd, mrd(r));
			chk("ta", ta, 32'h0);
			repeat ($unsigned($random(seed)) % 64) @(posedge ref_clk);
		end
		w = wr_seen;
		xfer(1'b1, 5'h0c, 5'h01, 16'h5a5a, rd, ta);
		chk("foreign write", wr_seen, w);
		xfer(1'b0, 5'h0c, 5'h01, 16'h0, rd, ta);
		chk("foreign read", rd, 32'hffff);
		chk("foreign ta", ta, 32'h1);
		xfer(1'b0, 5'h0b, 5'h01, 16'h0, rd, ta);
		chk("reg1", rd, mrd(1));
		xfer(1'b1, 5'h0b, 5'h0d, 16'h0000, rd, ta);
		xfer(1'b1, 5'h0b, 5'h0e, 16'h0003, rd, ta);
		xfer(1'b1, 5'h0b, 5'h0d, 16'h4000, rd, ta);
		xfer(1'b1, 5'h0b, 5'h0e, 16'hbeef, rd, ta);
		xfer(0, 5'h0b, 5'h0e, 16'h0, rd, ta);
		chk("ext data", rd, 32'hbeef);
		xfer(1'b1, 5'h0b, 5'h0d, 16'h8000, rd, ta);
		xfer(1'b0, 5'h0b, 5'h0e, 16'h0, rd, ta);
		chk("ext inc", rd, 32'hbeef);
		xfer(1'b0, 5'h0b, 5'h0e, 16'h0, rd, ta);
		chk("ext next", rd, 32'h0);
		xfer(1'b1, 5'h0b, 5'h0d, 16'h0000, rd, ta);
		xfer(1'b0, 5'h0b, 5'h0e, 16'h0, rd, ta);
		chk("ext addr", rd, 32'h5);
		print_verdict();
	end
endmodule : phy_mgmt_serial_slave_bench
